// ### hw/scas_pkg.sv
// Constants for the smart card activation sequencer.
// Assumes a 100 MHz mclk; the slow 32 kHz clock arrives as a plain input.
`default_nettype none
package scas_pkg;
  localparam int unsigned MCLK_HZ       = 100_000_000;
  localparam int unsigned CARD_HZ_DFLT  = 4_000_000;
  localparam int unsigned CARD_HZ_MIN   = 1_000_000;
  localparam int unsigned CARD_HZ_MAX   = 5_000_000;
  localparam int unsigned CARD_PINS     = 5;
  localparam int unsigned DATA_AT_T0    = 200;
  localparam int unsigned RESP_MIN      = 400;
  localparam int unsigned RESP_MAX      = 40_000;
  localparam int unsigned RST_LOW_CYC   = 40_000;
  localparam int unsigned RST_HIGH_CYC  = 40_000;
  localparam int unsigned ETU_NORMAL    = 372;
  localparam int unsigned ETU_FAST      = 16;
  localparam int unsigned CNT_W         = 16;
  localparam logic        OUT_RST_VAL   = 1'b0;

  typedef enum logic [2:0] {
    SCAS_IDLE  = 3'b000,
    SCAS_ACT   = 3'b001,
    SCAS_RSTLO = 3'b010,
    SCAS_WAIT  = 3'b011,
    SCAS_RUN   = 3'b100,
    SCAS_DEACT = 3'b101
  } scas_state_t;

  typedef enum logic [2:0] {
    SCAS_D_IDLE = 3'b000,
    SCAS_D_RST  = 3'b001,
    SCAS_D_CLK  = 3'b010,
    SCAS_D_DAT  = 3'b011,
    SCAS_D_VCC  = 3'b100
  } scas_dstep_t;
endpackage
`default_nettype wire

// ### hw/scas_clkgen.sv
// Card clock divider with 50 percent duty and a one-cycle rising-edge tick.
// Assumes mclk far above the card clock; HALF is mclk cycles per half period.
`default_nettype none
module scas_clkgen #(
  parameter int unsigned HALF = 13
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      clk_r,
  output logic      rise_r
);
  import scas_pkg::*;
  localparam int unsigned W = $clog2(HALF + 1);
  logic [W-1:0] cnt_r;

  initial begin
    if (HALF < 1) $error("scas_clkgen: HALF must be at least 1");
  end

  // Stops low when run drops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= '0;
      clk_r  <= 1'b0;
      rise_r <= 1'b0;
    end else if (!run) begin
      cnt_r  <= '0;
      clk_r  <= 1'b0;
      rise_r <= 1'b0;
    end else if (cnt_r == W'(HALF - 1)) begin
      cnt_r  <= '0;
      clk_r  <= ~clk_r;
      rise_r <= ~clk_r;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      rise_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### hw/scas_top.sv
// Smart card activation and deactivation sequencer.
// Assumes card pins and the slow clock are asynchronous to mclk.
//
// Contract
// RULE_01 - Five card pins, all treated asynchronous
// RULE_02 - Device supplies the card clock
// RULE_03 - Card clock 372 or 16 times bit rate
// RULE_04 - Card clock 1 to 5 MHz, half duty
// RULE_05 - Device starts session, card answers reset
// RULE_06 - Internal-reset and active-low-reset card variants
// RULE_07 - Clock at T0, data high by 200 cycles
// RULE_08 - Internal-reset card answers 400 to 40000 cycles
// RULE_09 - Reset low 40000 cycles, ignore replies
// RULE_10 - Reset high at T1 for 40000 cycles
// RULE_11 - Low-reset card answers 400 to 40000 after T1
// RULE_12 - Deactivate: reset, clock, data, supply in order
// RULE_13 - Steps one slow-clock period apart
// RULE_14 - Step spacing near one slow period each
// RULE_15 - Start on removal or processor command
// RULE_16 - Auto power down uses same sequence
// RULE_17 - Slow clock runs during deactivation
// RULE_18 - Sixteen-bit cycle counter, flag response timeout
`default_nettype none
module scas_top #(
  parameter int unsigned CARD_HZ  = scas_pkg::CARD_HZ_DFLT,
  parameter int unsigned RESP_MAXC = scas_pkg::RESP_MAX,
  parameter int unsigned RST_LOWC  = scas_pkg::RST_LOW_CYC
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic low_reset_card,
  input  wire logic fast_rate,
  input  wire logic deact_cmd,
  input  wire logic auto_pd,
  input  wire logic slow_32k_clock,
  input  wire logic card_presence_pin,
  input  wire logic card_data_line_in,
  output logic      card_data_line_out,
  output logic      card_data_line_oe,
  output logic      card_clock_out,
  output logic      card_reset_out,
  output logic      card_supply_enable,
  output logic      etu_fast_r,
  output logic      atr_seen_r,
  output logic      timeout_r,
  output logic      active_r,
  output logic      busy_r
);
  import scas_pkg::*;
  localparam int unsigned HALF = MCLK_HZ / (2 * CARD_HZ);

  initial begin
    if (CARD_HZ < CARD_HZ_MIN || CARD_HZ > CARD_HZ_MAX) $error("CARD_HZ out of range"); // RULE_04
    if (RESP_MAXC >= 2**CNT_W || RST_LOWC >= 2**CNT_W) $error("counts exceed counter");
  end

  // Two-stage synchronisers for pins and slow clock
  logic [2:0] s1_r, s2_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {slow_32k_clock, card_presence_pin, card_data_line_in}; // RULE_01
      s2_r <= s1_r;
    end
  end
  logic slow_s, pres_s, data_s, slow_d_r, data_d_r;
  assign slow_s = s2_r[2];
  assign pres_s = s2_r[1];
  assign data_s = s2_r[0];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slow_d_r <= 1'b0;
      data_d_r <= 1'b0;
    end else begin
      slow_d_r <= slow_s;
      data_d_r <= data_s;
    end
  end
  logic slow_tick, data_fall;
  assign slow_tick = slow_s & ~slow_d_r; // RULE_13 RULE_17
  assign data_fall = ~data_s & data_d_r;

  scas_state_t st_r, st_nxt;
  scas_dstep_t ds_r;
  logic [CNT_W-1:0] cnt_r;
  logic clk_run_r, card_clk, card_rise;

  scas_clkgen #(.HALF(HALF)) u_clk (
    .mclk   (mclk),
    .nrst   (nrst),
    .run    (clk_run_r),
    .clk_r  (card_clk),
    .rise_r (card_rise)
  ); // RULE_02

  // Removal taken on a slow tick, so reset falls one full period later
  logic go_down;
  assign go_down = (st_r != SCAS_IDLE) && (st_r != SCAS_DEACT) && slow_tick &&
                   (deact_cmd || auto_pd || !pres_s); // RULE_15 RULE_16

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SCAS_IDLE:  if (start && pres_s) st_nxt = SCAS_ACT; // RULE_05
      SCAS_ACT:   if (card_rise && cnt_r == CNT_W'(DATA_AT_T0 - 1))
                    st_nxt = low_reset_card ? SCAS_RSTLO : SCAS_WAIT; // RULE_06
      SCAS_RSTLO: if (card_rise && cnt_r == CNT_W'(RST_LOWC - 1)) st_nxt = SCAS_WAIT;
      SCAS_WAIT:  if (atr_seen_r || timeout_r) st_nxt = SCAS_RUN;
      SCAS_RUN:   st_nxt = SCAS_RUN;
      SCAS_DEACT: if (ds_r == SCAS_D_VCC && slow_tick) st_nxt = SCAS_IDLE;
      default:    st_nxt = SCAS_IDLE;
    endcase
    if (go_down) st_nxt = SCAS_DEACT;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) st_r <= SCAS_IDLE;
    else       st_r <= st_nxt;
  end

  // Card-clock cycle counter, restarted at T0 and T1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (st_nxt != st_r && st_nxt != SCAS_WAIT) begin
      cnt_r <= '0;
    end else if (st_r == SCAS_RSTLO && st_nxt == SCAS_WAIT) begin
      cnt_r <= '0; // RULE_10
    end else if (card_rise && cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1; // RULE_18
    end
  end

  // Answer window and timeout
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      atr_seen_r <= 1'b0;
      timeout_r  <= 1'b0;
    end else if (st_r == SCAS_IDLE && st_nxt == SCAS_ACT) begin
      atr_seen_r <= 1'b0;
      timeout_r  <= 1'b0;
    end else if (st_r == SCAS_WAIT && !atr_seen_r && !timeout_r) begin
      if (data_fall && cnt_r >= CNT_W'(RESP_MIN) && cnt_r <= CNT_W'(RESP_MAXC))
        atr_seen_r <= 1'b1; // RULE_08 RULE_11
      else if (cnt_r > CNT_W'(RESP_MAXC))
        timeout_r <= 1'b1; // RULE_18
    end
  end

  // Deactivation steps, one slow tick each
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ds_r <= SCAS_D_IDLE;
    end else if (st_r != SCAS_DEACT) begin
      ds_r <= SCAS_D_IDLE;
    end else if (slow_tick) begin
      unique case (ds_r)
        SCAS_D_IDLE: ds_r <= SCAS_D_RST; // RULE_12 RULE_14
        SCAS_D_RST:  ds_r <= SCAS_D_CLK;
        SCAS_D_CLK:  ds_r <= SCAS_D_DAT;
        SCAS_D_DAT:  ds_r <= SCAS_D_VCC;
        SCAS_D_VCC:  ds_r <= SCAS_D_VCC;
        default:     ds_r <= SCAS_D_IDLE;
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_run_r          <= 1'b0;
      card_clock_out     <= OUT_RST_VAL;
      card_reset_out     <= OUT_RST_VAL;
      card_supply_enable <= OUT_RST_VAL;
      card_data_line_out <= OUT_RST_VAL;
      card_data_line_oe  <= 1'b1;
    end else begin
      card_clock_out <= card_clk;
      if (st_r == SCAS_DEACT) begin
        if (ds_r == SCAS_D_RST || ds_r == SCAS_D_IDLE && slow_tick) card_reset_out <= 1'b0;
        if (ds_r == SCAS_D_RST && slow_tick) clk_run_r <= 1'b0; // RULE_12
        if (ds_r == SCAS_D_CLK && slow_tick) begin
          card_data_line_out <= 1'b0;
          card_data_line_oe  <= 1'b1;
        end
        if (ds_r == SCAS_D_DAT && slow_tick) card_supply_enable <= 1'b0;
      end else if (st_r == SCAS_IDLE) begin
        if (st_nxt == SCAS_ACT) begin
          card_supply_enable <= 1'b1;
          clk_run_r          <= 1'b1; // RULE_07
        end
        card_reset_out <= 1'b0;
      end else if (st_r == SCAS_ACT) begin
        if (card_rise && cnt_r == CNT_W'(DATA_AT_T0 - 1)) begin
          card_data_line_out <= 1'b1; // RULE_07
          card_data_line_oe  <= 1'b0;
          card_reset_out     <= ~low_reset_card; // RULE_09
        end
      end else if (st_r == SCAS_RSTLO && st_nxt == SCAS_WAIT) begin
        card_reset_out <= 1'b1; // RULE_10
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      etu_fast_r <= 1'b0;
      active_r   <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      if (st_r == SCAS_IDLE) etu_fast_r <= fast_rate; // RULE_03
      active_r <= (st_nxt == SCAS_RUN);
      busy_r   <= (st_nxt != SCAS_IDLE);
    end
  end

  a_clk_stop_order: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(clk_run_r) |-> !card_reset_out && card_supply_enable)
    else $error("clock stopped out of order"); // RULE_12
  a_supply_last: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(card_supply_enable) |-> !card_reset_out && !clk_run_r && !card_data_line_out)
    else $error("supply dropped out of order"); // RULE_12
  a_rst_low_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (st_r == SCAS_RSTLO) |-> !card_reset_out)
    else $error("reset rose early"); // RULE_09
  a_rst_rise_count: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(card_reset_out) && low_reset_card |-> $past(cnt_r) == CNT_W'(RST_LOWC - 1))
    else $error("reset low period wrong"); // RULE_10
  a_data_by_200: assert property (@(posedge mclk) disable iff (!nrst)
    (st_r == SCAS_ACT) |-> cnt_r <= CNT_W'(DATA_AT_T0))
    else $error("data late"); // RULE_07
  a_atr_window: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(atr_seen_r) |-> $past(cnt_r) >= CNT_W'(RESP_MIN))
    else $error("answer outside window"); // RULE_11
  a_timeout_set: assert property (@(posedge mclk) disable iff (!nrst)
    (st_r == SCAS_WAIT && !atr_seen_r && !timeout_r && cnt_r > CNT_W'(RESP_MAXC))
    |=> timeout_r)
    else $error("timeout missed"); // RULE_18
  a_removal_deact: assert property (@(posedge mclk) disable iff (!nrst)
    (st_r == SCAS_RUN && slow_tick && (!pres_s || deact_cmd || auto_pd))
    |=> st_r == SCAS_DEACT)
    else $error("deactivation not started"); // RULE_15
endmodule
`default_nettype wire

// ### dv/scas_card.sv
// Behavioural card on the far side of the sequencer's five pins.
// Assumes the bench resolves the data line with a pull-up.
`default_nettype none
module scas_card (
  input  wire logic        card_clock_out,
  input  wire logic        card_reset_out,
  input  wire logic        card_supply_enable,
  input  wire logic        low_reset_card,
  input  wire logic [15:0] resp_cyc,
  output logic             card_tx_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // Count from T0, or from T1 for an active-low-reset card
  always @(posedge card_supply_enable or posedge card_reset_out) begin
    if (card_supply_enable && (card_reset_out == low_reset_card)) n = 0;
  end
  always @(posedge card_clock_out) n = n + 1;
  // Answer once; an active-low-reset card stays silent while reset is held low
  assign card_tx_low = card_supply_enable && (!low_reset_card || card_reset_out)
                       && n >= resp_cyc && n < resp_cyc + 30;
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the activation sequencer against a card model.
// Assumes a fast stand-in for the slow clock, 8 mclk cycles a period.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scas_pkg::*;
  localparam int RMAX = 600;
  localparam int RLOW = 500;
  localparam int SP   = 8;
  logic        mclk, nrst, start, low_reset_card, fast_rate, deact_cmd, auto_pd;
  logic        slow_32k_clock, card_presence_pin, card_tx_low;
  logic        card_data_line_out, card_data_line_oe, card_clock_out, card_reset_out;
  logic        card_supply_enable, etu_fast_r, atr_seen_r, timeout_r, active_r, busy_r;
  logic [15:0] resp_cyc;
  wire         card_data_line;
  int          bad_count, checked, seed, cyc, rises;
  assign card_data_line = card_data_line_oe ? card_data_line_out : !card_tx_low;
  scas_top #(.RESP_MAXC(RMAX), .RST_LOWC(RLOW)) u_scas_top (
    .mclk(mclk), .nrst(nrst), .start(start), .low_reset_card(low_reset_card),
    .fast_rate(fast_rate), .deact_cmd(deact_cmd), .auto_pd(auto_pd),
    .slow_32k_clock(slow_32k_clock), .card_presence_pin(card_presence_pin),
    .card_data_line_in(card_data_line), .card_data_line_out(card_data_line_out),
    .card_data_line_oe(card_data_line_oe), .card_clock_out(card_clock_out),
    .card_reset_out(card_reset_out), .card_supply_enable(card_supply_enable),
    .etu_fast_r(etu_fast_r), .atr_seen_r(atr_seen_r), .timeout_r(timeout_r),
    .active_r(active_r), .busy_r(busy_r));
  scas_card u_scas_card (
    .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
    .card_supply_enable(card_supply_enable), .low_reset_card(low_reset_card),
    .resp_cyc(resp_cyc), .card_tx_low(card_tx_low));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Free-running slow clock, phase unrelated to mclk
  initial begin
    slow_32k_clock = 1'b0;
    #3;
    forever #40 slow_32k_clock = ~slow_32k_clock;
  end
  always @(posedge card_clock_out) rises++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (checked > 0 && bad_count == 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic activate(input logic low, input logic [15:0] resp, input logic ok);
    int w, hi, lo;
    fast_rate = 1'($random(seed));
    low_reset_card = low;
    resp_cyc = resp;
    repeat (3) tick();
    chk(etu_fast_r, fast_rate);
    start = 1'b1;
    tick();
    start = 1'b0;
    rises = 0;
    hi = 0;
    lo = 0;
    tick();
    chk(card_supply_enable, 1);
    for (w = 0; w < 9000 && card_data_line_oe !== 1'b0; w++) begin
      tick();
      if (card_clock_out) hi++;
      else lo++;
    end
    chk(rises <= DATA_AT_T0 && rises + 1 >= DATA_AT_T0, 1);
    chk(hi + lo >= 20 * rises && hi + lo <= 100 * rises, 1);
    chk(hi + 30 > lo && hi < lo + 30, 1);
    if (low) begin
      for (w = 0; w < 20000 && card_reset_out !== 1'b1; w++) tick();
      chk(rises >= RLOW, 1);
    end
    for (w = 0; w < 20000 && active_r !== 1'b1; w++) begin
      tick();
      if (low) chk(card_reset_out, 1);
    end
    chk(atr_seen_r, ok);
    chk(timeout_r, !ok);
    $display("activation low=%0d resp=%0d done", low, resp);
  endtask
  task automatic deactivate(input int how);
    int w, t_clk, t_dat, t_ven;
    logic pc;
    case (how)
      0: deact_cmd = 1'b1;
      1: auto_pd = 1'b1;
      default: card_presence_pin = 1'b0;
    endcase
    for (w = 0; w < 40 && card_reset_out !== 1'b0; w++) tick();
    if (how == 2) chk(w >= SP + 3 && w <= 2 * SP + 3, 1);
    t_clk = 0;
    t_dat = 0;
    t_ven = 0;
    pc = card_clock_out;
    for (w = 1; w < 40; w++) begin
      tick();
      if (card_clock_out !== pc) t_clk = w;
      pc = card_clock_out;
      if (t_dat == 0 && card_data_line_oe && !card_data_line_out) t_dat = w;
      if (t_ven == 0 && !card_supply_enable) t_ven = w;
    end
    chk(t_clk <= SP + 3 && pc === 1'b0, 1);
    chk(t_dat >= 2 * SP - 3 && t_dat <= 2 * SP + 3, 1);
    chk(t_ven >= 3 * SP - 3 && t_ven <= 3 * SP + 3, 1);
    chk(busy_r, 0);
    deact_cmd = 1'b0;
    auto_pd = 1'b0;
    card_presence_pin = 1'b1;
    $display("deactivation via %0d done", how);
  endtask
  initial begin
    seed = 32'h1ad2_9c89;
    bad_count = 0;
    checked = 0;
    cyc = 0;
    rises = 0;
    nrst = 1'b0;
    start = 1'b0;
    low_reset_card = 1'b0;
    fast_rate = 1'b0;
    deact_cmd = 1'b0;
    auto_pd = 1'b0;
    card_presence_pin = 1'b1;
    resp_cyc = 16'h01f4;
    repeat (2) tick();
    chk({card_supply_enable, card_data_line_oe, card_clock_out}, 3'h2);
    nrst = 1'b1;
    activate(1'b0, 16'(410 + {$random(seed)} % 170), 1'b1);
    deactivate(0);
    activate(1'b0, 16'h015e, 1'b0);
    deactivate(1);
    activate(1'b1, 16'h01c2, 1'b1);
    deactivate(2);
    deact_cmd = 1'b1;
    repeat (4 * SP) tick();
    chk(busy_r, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
